/* logic/xs_pkg.sv */
package xs_pkg;

    // ============================================================
    // Array geometry
    localparam int XS_ROWS  = 12;
    localparam int XS_COLS  = 8;
    localparam int XS_NSW   = 96;

    // ============================================================
    // Address byte and word fields
    localparam logic [3:0] XS_ADDR_MSB  = 4'hE;
    localparam logic       XS_DIR_READ  = 1'h1;
    localparam logic       XS_DIR_WRITE = 1'h0;
    localparam int         XS_DATA_BIT  = 7;
    localparam int         XS_ROW_MSB   = 6;
    localparam int         XS_ROW_LSB   = 3;
    localparam int         XS_COL_MSB   = 2;
    localparam int         XS_LOAD_BIT  = 0;
    localparam logic [3:0] XS_BIT_ACK   = 4'h8;
    localparam logic [3:0] XS_BIT_DONE  = 4'h9;
    localparam logic [1:0] XS_BYTE_HI   = 2'h1;
    localparam logic [1:0] XS_BYTE_LO   = 2'h2;
    localparam logic [3:0] XS_WR_BYTES  = 4'h3;

    // ============================================================
    // Reset values
    localparam logic [5:0] XS_PIN_RST   = 6'h07;

    // ============================================================
    // Timing
    localparam int XS_MCLK_NS       = 50;
    localparam int XS_SCL_PERIOD_NS = 2500;
    localparam int XS_QTR_CYC       = XS_SCL_PERIOD_NS / 4 / XS_MCLK_NS;

    // ============================================================
    // State machines
    typedef enum logic [2:0] {
        DS_IDLE   = 3'h0,
        DS_ADDR   = 3'h1,
        DS_WRITE  = 3'h2,
        DS_READ   = 3'h3,
        DS_IGNORE = 3'h4
    } xs_dev_state_t;

    typedef enum logic [1:0] {
        HS_IDLE  = 2'h0,
        HS_START = 2'h1,
        HS_BIT   = 2'h2,
        HS_STOP  = 2'h3
    } xs_host_state_t;

endpackage

/* logic/xs_i2c_if.sv */
`timescale 1ns/1ns
interface xs_i2c_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic rst_pin_n;
    logic scl;
    logic sda;

    // ============================================================
    // Open-drain wire levels with pull-ups
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport dev (
        input  scl,
        input  sda,
        input  rst_pin_n,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport host (
        input  scl,
        input  sda,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe,
        output rst_pin_n
    );
endinterface

/* logic/xs_dev.sv */
`timescale 1ns/1ns
module xs_dev
    import xs_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    // Address select pins
    input  wire logic              addr_select_bit0_i,
    input  wire logic              addr_select_bit1_i,
    input  wire logic              addr_select_bit2_i,
    // Serial bus
    xs_i2c_if.dev                  bus,
    // Switch array, bit row*8+col
    output logic [XS_NSW-1:0]      switch_state_o
);

    // ============================================================
    // Input synchronisers
    logic [5:0]          in_raw;
    logic [5:0]          sync1_ff;
    logic [5:0]          sync2_ff;
    logic [5:0]          sync3_ff;
    logic [5:0]          clean_ff;
    logic [5:0]          prev_ff;
    logic [5:0]          nxt_clean;

    assign in_raw    = {addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i,
                        bus.rst_pin_n, bus.sda, bus.scl};
    // Accept a change once stages two and three agree
    assign nxt_clean = (sync2_ff & sync3_ff) | (clean_ff & (sync2_ff ^ sync3_ff));

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sync1_ff <= XS_PIN_RST;
            sync2_ff <= XS_PIN_RST;
            sync3_ff <= XS_PIN_RST;
            clean_ff <= XS_PIN_RST;
            prev_ff  <= XS_PIN_RST;
        end else begin
            sync1_ff <= in_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            clean_ff <= nxt_clean;
            prev_ff  <= clean_ff;
        end
    end

    // ============================================================
    // Bus events
    logic                scl_c;
    logic                sda_c;
    logic                pin_clear;
    logic [2:0]          sel_c;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_det;
    logic                stop_det;

    assign scl_c     = clean_ff[0];
    assign sda_c     = clean_ff[1];
    assign pin_clear = ~clean_ff[2];
    assign sel_c     = clean_ff[5:3];
    assign scl_rise  = scl_c & ~prev_ff[0];
    assign scl_fall  = ~scl_c & prev_ff[0];
    assign start_det = scl_c & prev_ff[0] & prev_ff[1] & ~sda_c;
    assign stop_det  = scl_c & prev_ff[0] & ~prev_ff[1] & sda_c;

    // ============================================================
    // State
    xs_dev_state_t       st_ff;
    logic [3:0]          cnt_ff;
    logic [7:0]          shift_ff;
    logic [7:0]          wbyte_ff;
    logic [7:0]          tx_ff;
    logic [1:0]          byte_ff;
    logic [3:0]          rd_row_ff;
    logic                mnak_ff;
    logic                sda_oe_ff;
    logic [XS_NSW-1:0]   staged_ff;
    logic [XS_NSW-1:0]   applied_ff;

    // ============================================================
    // Decode
    logic                active;
    logic                addr_match;
    logic [3:0]          row_index;
    logic [2:0]          column_index;
    logic                sw_data;
    logic                load_switch_bit;
    logic                row_ok;
    logic [6:0]          sw_idx;
    logic [XS_NSW-1:0]   sw_mask;
    logic [XS_NSW-1:0]   nxt_staged;
    logic [7:0]          rd_byte;
    logic [3:0]          nxt_row;

    assign active          = (st_ff != DS_IDLE) && (st_ff != DS_IGNORE);
    assign addr_match      = shift_ff[7:1] == {XS_ADDR_MSB, sel_c};
    assign row_index       = wbyte_ff[XS_ROW_MSB:XS_ROW_LSB];
    assign column_index    = wbyte_ff[XS_COL_MSB:0];
    assign sw_data         = wbyte_ff[XS_DATA_BIT];
    assign load_switch_bit = shift_ff[XS_LOAD_BIT];
    assign row_ok          = row_index < 4'(XS_ROWS);
    assign sw_idx          = {row_index, column_index};
    assign sw_mask         = row_ok ? (XS_NSW'(1) << sw_idx) : '0;
    assign nxt_staged      = sw_data ? (staged_ff | sw_mask)
                                     : (staged_ff & ~sw_mask);
    assign rd_byte         = applied_ff[{rd_row_ff, 3'h0} +: 8];
    assign nxt_row         = (rd_row_ff == 4'(XS_ROWS - 1)) ? 4'h0 : rd_row_ff + 4'h1;

    // ============================================================
    // Protocol engine
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || pin_clear) begin
            st_ff      <= DS_IDLE;
            cnt_ff     <= 4'h0;
            shift_ff   <= 8'h00;
            wbyte_ff   <= 8'h00;
            tx_ff      <= 8'h00;
            byte_ff    <= 2'h0;
            rd_row_ff  <= 4'h0;
            mnak_ff    <= 1'b0;
            sda_oe_ff  <= 1'b0;
            staged_ff  <= '0;
            applied_ff <= '0;
        end else if (start_det) begin
            st_ff     <= DS_ADDR;
            cnt_ff    <= 4'h0;
            byte_ff   <= 2'h0;
            rd_row_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
        end else if (stop_det) begin
            st_ff     <= DS_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (scl_rise && active) begin
            if (cnt_ff < XS_BIT_ACK) begin
                shift_ff <= {shift_ff[6:0], sda_c};
                cnt_ff   <= cnt_ff + 4'h1;
            end else begin
                mnak_ff <= sda_c;
                cnt_ff  <= XS_BIT_DONE;
            end
        end else if (scl_fall && active) begin
            if (cnt_ff == XS_BIT_ACK) begin
                case (st_ff)
                    DS_ADDR: begin
                        if (addr_match) begin
                            sda_oe_ff <= 1'b1;
                        end else begin
                            st_ff <= DS_IGNORE;
                        end
                    end
                    DS_WRITE: begin
                        sda_oe_ff <= 1'b1;
                        if (byte_ff == XS_BYTE_HI) begin
                            wbyte_ff <= shift_ff;
                        end
                    end
                    default: begin
                        sda_oe_ff <= 1'b0;
                    end
                endcase
            end else if (cnt_ff == XS_BIT_DONE) begin
                cnt_ff    <= 4'h0;
                sda_oe_ff <= 1'b0;
                case (st_ff)
                    DS_ADDR: begin
                        if (shift_ff[0] == XS_DIR_READ) begin
                            st_ff     <= DS_READ;
                            sda_oe_ff <= ~rd_byte[7];
                            tx_ff     <= {rd_byte[6:0], 1'b0};
                            rd_row_ff <= nxt_row;
                        end else begin
                            st_ff   <= DS_WRITE;
                            byte_ff <= XS_BYTE_HI;
                        end
                    end
                    DS_WRITE: begin
                        if (byte_ff == XS_BYTE_LO) begin
                            byte_ff   <= XS_BYTE_HI;
                            staged_ff <= nxt_staged;
                            if (load_switch_bit) begin
                                applied_ff <= nxt_staged;
                            end
                        end else begin
                            byte_ff <= XS_BYTE_LO;
                        end
                    end
                    DS_READ: begin
                        if (mnak_ff) begin
                            st_ff <= DS_IGNORE;
                        end else begin
                            sda_oe_ff <= ~rd_byte[7];
                            tx_ff     <= {rd_byte[6:0], 1'b0};
                            rd_row_ff <= nxt_row;
                        end
                    end
                    default: begin
                        st_ff <= DS_IGNORE;
                    end
                endcase
            end else if (st_ff == DS_READ && cnt_ff != 4'h0) begin
                sda_oe_ff <= ~tx_ff[7];
                tx_ff     <= {tx_ff[6:0], 1'b0};
            end
        end
    end

    // ============================================================
    // Outputs; the serial clock is only ever sampled
    assign bus.dev_sda_o  = 1'b0;
    assign bus.dev_sda_oe = sda_oe_ff;
    assign switch_state_o = applied_ff;

endmodule

/* logic/xs_host.sv */
`timescale 1ns/1ns
module xs_host
    import xs_pkg::*;
#(
    parameter int QTR_CYC = XS_QTR_CYC
)
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    // Command
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_read_i,
    input  wire logic [6:0]  cmd_dev_addr_i,
    input  wire logic [15:0] cmd_word_i,
    input  wire logic [3:0]  cmd_rd_len_i,
    input  wire logic        pin_reset_i,
    output logic             cmd_ready_o,
    // Results
    output logic [7:0]       rd_data_o,
    output logic             rd_valid_o,
    output logic             done_o,
    output logic             nak_o,
    // Serial bus
    xs_i2c_if.host           bus
);

    // ============================================================
    // Data line synchroniser
    logic [2:0]     sda_sync_ff;
    logic           sda_c_ff;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sda_sync_ff <= 3'h7;
            sda_c_ff    <= 1'b1;
        end else begin
            sda_sync_ff <= {sda_sync_ff[1:0], bus.sda};
            if (sda_sync_ff[1] == sda_sync_ff[2]) begin
                sda_c_ff <= sda_sync_ff[2];
            end
        end
    end

    // ============================================================
    // State
    xs_host_state_t st_ff;
    logic [15:0]    div_ff;
    logic [1:0]     q_ff;
    logic [3:0]     bit_ff;
    logic [3:0]     left_ff;
    logic [7:0]     tx_ff;
    logic [7:0]     rx_ff;
    logic [15:0]    word_ff;
    logic           rd_ff;
    logic           send_ff;
    logic           scl_oe_ff;
    logic           sda_oe_ff;
    logic           ready_ff;
    logic           rstpin_ff;
    logic           tick;
    logic           take;
    logic           ack_drive;

    assign tick      = div_ff == 16'(QTR_CYC - 1);
    assign take      = cmd_valid_i && ready_ff && !pin_reset_i;
    // Master acks read bytes except the last
    assign ack_drive = !send_ff && (left_ff != 4'h1);

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_ff      <= HS_IDLE;
            div_ff     <= 16'h0000;
            q_ff       <= 2'h0;
            bit_ff     <= 4'h0;
            left_ff    <= 4'h0;
            tx_ff      <= 8'h00;
            rx_ff      <= 8'h00;
            word_ff    <= 16'h0000;
            rd_ff      <= 1'b0;
            send_ff    <= 1'b0;
            scl_oe_ff  <= 1'b0;
            sda_oe_ff  <= 1'b0;
            ready_ff   <= 1'b0;
            rstpin_ff  <= 1'b1;
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
            done_o     <= 1'b0;
            nak_o      <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            done_o     <= 1'b0;
            nak_o      <= 1'b0;
            div_ff     <= (tick || st_ff == HS_IDLE) ? 16'h0000 : div_ff + 16'h0001;
            if (tick) begin
                q_ff <= q_ff + 2'h1;
            end
            case (st_ff)
                HS_IDLE: begin
                    rstpin_ff <= ~pin_reset_i;
                    ready_ff  <= ~pin_reset_i;
                    q_ff      <= 2'h0;
                    if (take) begin
                        ready_ff <= 1'b0;
                        st_ff    <= HS_START;
                        rd_ff    <= cmd_read_i;
                        send_ff  <= 1'b1;
                        tx_ff    <= {cmd_dev_addr_i, cmd_read_i};
                        word_ff  <= cmd_word_i;
                        left_ff  <= cmd_read_i ? cmd_rd_len_i + 4'h1 : XS_WR_BYTES;
                        bit_ff   <= 4'h0;
                    end
                end
                HS_START: begin
                    if (tick && q_ff == 2'h1) begin
                        sda_oe_ff <= 1'b1;
                    end
                    if (tick && q_ff == 2'h3) begin
                        st_ff <= HS_BIT;
                    end
                end
                HS_BIT: begin
                    if (tick) begin
                        case (q_ff)
                            2'h0: scl_oe_ff <= 1'b1;
                            2'h1: begin
                                if (bit_ff < XS_BIT_ACK) begin
                                    sda_oe_ff <= send_ff & ~tx_ff[7];
                                end else begin
                                    sda_oe_ff <= ack_drive;
                                end
                            end
                            2'h2: scl_oe_ff <= 1'b0;
                            default: begin
                                if (bit_ff < XS_BIT_ACK) begin
                                    rx_ff  <= {rx_ff[6:0], sda_c_ff};
                                    tx_ff  <= {tx_ff[6:0], 1'b0};
                                    bit_ff <= bit_ff + 4'h1;
                                end else begin
                                    bit_ff  <= 4'h0;
                                    left_ff <= left_ff - 4'h1;
                                    send_ff <= ~rd_ff;
                                    tx_ff   <= word_ff[15:8];
                                    word_ff <= {word_ff[7:0], 8'h00};
                                    if (!send_ff) begin
                                        rd_data_o  <= rx_ff;
                                        rd_valid_o <= 1'b1;
                                    end
                                    if (send_ff && sda_c_ff) begin
                                        nak_o <= 1'b1;
                                        st_ff <= HS_STOP;
                                    end else if (left_ff == 4'h1) begin
                                        st_ff <= HS_STOP;
                                    end
                                end
                            end
                        endcase
                    end
                end
                HS_STOP: begin
                    if (tick) begin
                        case (q_ff)
                            2'h0: scl_oe_ff <= 1'b1;
                            2'h1: sda_oe_ff <= 1'b1;
                            2'h2: scl_oe_ff <= 1'b0;
                            default: begin
                                sda_oe_ff <= 1'b0;
                                st_ff     <= HS_IDLE;
                                done_o    <= 1'b1;
                            end
                        endcase
                    end
                end
                default: st_ff <= HS_IDLE;
            endcase
        end
    end

    // ============================================================
    // Outputs
    assign cmd_ready_o     = ready_ff;
    assign bus.host_scl_o  = 1'b0;
    assign bus.host_scl_oe = scl_oe_ff;
    assign bus.host_sda_o  = 1'b0;
    assign bus.host_sda_oe = sda_oe_ff;
    assign bus.rst_pin_n   = rstpin_ff;

endmodule

/* tb/xs_i2c_monitor.sv */
`timescale 1ns/1ns
module xs_i2c_monitor (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Bus wires and enables
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic host_scl_oe_i,
    input wire logic host_sda_oe_i,
    input wire logic dev_sda_oe_i,
    input wire logic rst_pin_n_i
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    // ========================================
    // Wire checks
    AST_SCL_HOST_ONLY: assert property (
        !scl_i |-> host_scl_oe_i)
        else $error("serial clock low with no host drive");
    AST_DEV_STABLE_HIGH: assert property (
        scl_i && $past(scl_i) |-> $stable(dev_sda_oe_i))
        else $error("device data moved while clock high");
    AST_DEV_RISE_LOW: assert property (
        $rose(dev_sda_oe_i) |-> !scl_i && !$past(scl_i, 3))
        else $error("device drive began outside clock low");
    AST_DEV_FALL_LOW: assert property (
        $fell(dev_sda_oe_i) |-> !scl_i && !$past(scl_i, 3))
        else $error("device release outside clock low");
    AST_DEV_HOLD: assert property (
        $rose(dev_sda_oe_i) |-> dev_sda_oe_i [*6])
        else $error("device low bit too short");
    AST_STOP_RELEASE: assert property (
        scl_i && $rose(sda_i) |-> (!dev_sda_oe_i) [*8])
        else $error("device drove data after stop");
    AST_START_BY_HOST: assert property (
        scl_i && $past(scl_i) && $fell(sda_i) |-> host_sda_oe_i && !dev_sda_oe_i)
        else $error("start not made by host");
    AST_PIN_RESET_QUIET: assert property (
        (!rst_pin_n_i) [*6] |-> !dev_sda_oe_i)
        else $error("device drives bus while reset pin low");

    // ========================================
    // Coverage
    cover property ($rose(dev_sda_oe_i));
    cover property (scl_i && $rose(sda_i));
    cover property ($fell(rst_pin_n_i));
endmodule

/* tb/crosspoint_switch_i2c_ctrl_tb.sv */
`timescale 1ns/1ns
module crosspoint_switch_i2c_ctrl_tb;
    import xs_pkg::*;
    logic              mclk_i = 1'h0;
    logic              reset_n_i = 1'h0;
    logic [2:0]        sel = 3'h5;
    logic              cmd_valid = 1'h0;
    logic              cmd_read = 1'h0;
    logic [6:0]        cmd_addr = 7'h00;
    logic [15:0]       cmd_word = 16'h0000;
    logic [3:0]        cmd_len = 4'h1;
    logic              pin_reset = 1'h0;
    logic              cmd_ready, rd_valid, done, nak, got_nak;
    logic [7:0]        rd_data;
    logic [XS_NSW-1:0] sw_state, want, pend;
    logic [7:0]        rx [$];
    int                num_errors = 0;
    int                check_count = 0;

    xs_i2c_if bus ();
    xs_dev i_xs_dev (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_select_bit0_i(sel[0]),
        .addr_select_bit1_i(sel[1]), .addr_select_bit2_i(sel[2]), .bus(bus),
        .switch_state_o(sw_state));
    xs_host #(.QTR_CYC(6)) i_xs_host (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid),
        .cmd_read_i(cmd_read), .cmd_dev_addr_i(cmd_addr), .cmd_word_i(cmd_word),
        .cmd_rd_len_i(cmd_len), .pin_reset_i(pin_reset), .cmd_ready_o(cmd_ready),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .done_o(done), .nak_o(nak), .bus(bus));
    xs_i2c_monitor i_xs_i2c_monitor (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .scl_i(bus.scl), .sda_i(bus.sda),
        .host_scl_oe_i(bus.host_scl_oe), .host_sda_oe_i(bus.host_sda_oe),
        .dev_sda_oe_i(bus.dev_sda_oe), .rst_pin_n_i(bus.rst_pin_n));

    always #25 mclk_i = ~mclk_i;

    // ========================================
    // Tasks
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: value mismatch", $time);
            num_errors++;
        end
    endtask

    task automatic run(input logic rd, input logic [6:0] a, input logic [15:0] w,
                       input logic [3:0] n);
        int t;
        t = 0;
        got_nak = 1'h0;
        rx.delete();
        while (cmd_ready !== 1'h1) @(negedge mclk_i);
        cmd_read = rd;
        cmd_addr = a;
        cmd_word = w;
        cmd_len = n;
        cmd_valid = 1'h1;
        @(negedge mclk_i);
        cmd_valid = 1'h0;
        while (done !== 1'h1 && t < 4000) begin
            @(negedge mclk_i);
            if (rd_valid === 1'h1) rx.push_back(rd_data);
            if (nak === 1'h1) got_nak = 1'h1;
            t++;
        end
        chk(t < 4000, 1'h1);
    endtask

    task automatic wr(input int r, input int c, input logic d, input logic ld);
        run(1'h0, {XS_ADDR_MSB, sel}, {d, 4'(r), 3'(c), 7'h00, ld}, 4'h1);
        if (r < XS_ROWS) pend[r*XS_COLS+c] = d;
        if (ld) want = pend;
        chk(sw_state, want);
        chk(got_nak, 1'h0);
    endtask

    task automatic conclude();
        if (num_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ========================================
    // Sequence
    initial begin
        repeat (6) @(negedge mclk_i);
        reset_n_i = 1'h1;
        repeat (2) @(negedge mclk_i);
        pend = '0;
        want = '0;
        chk(sw_state, '0);
        wr(11, 7, 1'h1, 1'h1);
        wr(0, 0, 1'h1, 1'h0);
        wr(5, 3, 1'h1, 1'h0);
        wr(2, 1, 1'h1, 1'h1);
        wr(11, 7, 1'h0, 1'h1);
        wr(12, 2, 1'h1, 1'h1);
        for (int i = 0; i < 2; i++) begin
            run(1'h0, i ? {4'h6, sel} : {XS_ADDR_MSB, ~sel}, 16'h8001, 4'h1);
            chk(got_nak, 1'h1);
            chk(sw_state, want);
        end
        run(1'h1, {XS_ADDR_MSB, sel}, 16'h0000, 4'hD);
        chk(rx.size(), 13);
        for (int r = 0; r < 13; r++) chk(rx[r], want[(r % XS_ROWS)*XS_COLS +: 8]);
        wr(6, 6, 1'h1, 1'h0);
        pin_reset = 1'h1;
        sel = 3'h2;
        repeat (12) @(negedge mclk_i);
        chk(sw_state, '0);
        pin_reset = 1'h0;
        repeat (4) @(negedge mclk_i);
        pend = '0;
        want = '0;
        wr(3, 4, 1'h1, 1'h1);
        run(1'h0, {XS_ADDR_MSB, 3'h5}, 16'h8001, 4'h1);
        chk(got_nak, 1'h1);
        chk(sw_state, want);
        conclude();
    end

    initial begin
        repeat (30000) @(posedge mclk_i);
        num_errors++;
        conclude();
    end
endmodule
